// ### tsc_pkg.sv
package tsc_pkg;

  // Register indexes; the byte address is four times the index.
  localparam logic [9:0] IDX_STROBE = 10'h000;
  localparam logic [9:0] IDX_CFG    = 10'h010;
  localparam logic [9:0] IDX_CFG_HI = 10'h011;
  localparam logic [9:0] IDX_DLY_B0 = 10'h014;
  localparam logic [9:0] IDX_DLY_B1 = 10'h015;
  localparam logic [9:0] IDX_DLY_W1 = 10'h016;
  localparam logic [9:0] IDX_DLY_B3 = 10'h017;
  localparam logic [9:0] IDX_STATUS = 10'h018;

  // Software strobe byte codes.
  localparam logic [7:0] STROBE_START = 8'h55;
  localparam logic [7:0] STROBE_STOP  = 8'hAA;
  localparam logic [7:0] STROBE_SYNC  = 8'h5A;

  // Configuration word layout.
  localparam int CFG_START_LSB = 0;
  localparam int CFG_STOP_LSB  = 4;
  localparam int CFG_SYNC_LSB  = 8;
  localparam int CFG_MODE_LSB  = 12;
  localparam int CFG_ARM_BIT   = 15;
  localparam logic [15:0] CFG_WRITE_MASK = 16'hBFFF;
  localparam logic [15:0] CFG_RESET      = 16'h0000;
  localparam logic [31:0] DLY_RESET      = 32'h0000_0000;

  // Status word layout.
  localparam int STAT_RUN_BIT   = 0;
  localparam int STAT_SYNC_BIT  = 1;
  localparam int STAT_DELAY_BIT = 2;
  localparam int STAT_IDLE_BIT  = 3;

  // Source selector codes.
  localparam logic [3:0] SRC_NONE        = 4'h0;
  localparam logic [3:0] SRC_SOFT        = 4'h1;
  localparam logic [3:0] SRC_FRAME_MAX   = 4'h2;
  localparam logic [3:0] SRC_FRAME_TIMER = 4'h3;

  // Start mode codes.
  localparam logic [1:0] MODE_DIRECT     = 2'h0;
  localparam logic [1:0] MODE_DELAY      = 2'h1;
  localparam logic [1:0] MODE_SYNC_DELAY = 2'h2;

  // Delay step timing.
  localparam logic [5:0] CLK_PERIOD_NS = 6'h08;
  localparam logic [5:0] DELAY_STEP_NS = 6'h19;

  // Bus responses.
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {ST_IDLE, ST_WAIT_SYNC, ST_DELAY, ST_RUN} tsc_state_t;

  typedef struct packed {
    logic        awvalid;
    logic [11:0] awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [11:0] araddr;
    logic        rready;
  } tsc_axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } tsc_axi_rsp_t;

endpackage : tsc_pkg

// ### tsc_edge_sync.sv
`timescale 1ns/1ps
module tsc_edge_sync #(
  parameter int WIDTH = 6
) (
  // Clock and reset
  input  logic             core_clk,
  input  logic             reset_n,
  // Raw levels
  input  logic [WIDTH-1:0] sig_in,
  // One-cycle edge pulses
  output logic [WIDTH-1:0] rise,
  output logic [WIDTH-1:0] fall
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] last_q;
  logic [WIDTH-1:0] rise_q;
  logic [WIDTH-1:0] fall_q;

  // Only the second stage and its delayed copy feed the edge compare.
  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      meta_q <= '0;
      sync_q <= '0;
      last_q <= '0;
      rise_q <= '0;
      fall_q <= '0;
    end
    else
    begin
      meta_q <= sig_in;
      sync_q <= meta_q;
      last_q <= sync_q;
      rise_q <= sync_q & ~last_q;
      fall_q <= ~sync_q & last_q;
    end
  end

  assign rise = rise_q;
  assign fall = fall_q;

endmodule : tsc_edge_sync

// ### tsc_trigger_ctrl.sv
`timescale 1ns/1ps
module tsc_trigger_ctrl (
  // Clock and reset
  input  logic                  core_clk,
  input  logic                  reset_n,
  // Register bus
  input  tsc_pkg::tsc_axi_req_t axi_req,
  output tsc_pkg::tsc_axi_rsp_t axi_rsp,
  // Counter outputs and digital inputs
  input  logic                  timer0_output,
  input  logic                  timer2_output,
  input  logic                  digital_input_0,
  input  logic                  digital_input_1,
  input  logic                  digital_input_2,
  input  logic                  digital_input_3,
  // Analog input frame events, one-cycle pulses
  input  logic                  ai_frame_max,
  input  logic                  ai_frame_timer,
  // Acquisition control
  output logic                  acq_run,
  output logic                  start_pulse,
  output logic                  stop_pulse
);

  function automatic logic is_mapped(input logic [9:0] idx);
    is_mapped = (idx == tsc_pkg::IDX_STROBE) || (idx == tsc_pkg::IDX_CFG) ||
                (idx == tsc_pkg::IDX_CFG_HI) || (idx == tsc_pkg::IDX_DLY_B0) ||
                (idx == tsc_pkg::IDX_DLY_B1) || (idx == tsc_pkg::IDX_DLY_W1) ||
                (idx == tsc_pkg::IDX_DLY_B3) || (idx == tsc_pkg::IDX_STATUS);
  endfunction : is_mapped

  function automatic logic [31:0] merge_bytes(input logic [31:0] old_val,
                                              input logic [31:0] new_val,
                                              input logic [3:0]  be);
    logic [31:0] res;
    res = old_val;
    for (int b = 0; b < 4; b++)
    begin
      if (be[b])
      begin
        res[8*b +: 8] = new_val[8*b +: 8];
      end
    end
    merge_bytes = res;
  endfunction : merge_bytes

  function automatic logic pick_event(input logic [15:0] vec, input logic [3:0] code);
    pick_event = vec[code];
  endfunction : pick_event

  tsc_pkg::tsc_axi_rsp_t rsp_q;
  tsc_pkg::tsc_state_t   state_q;
  tsc_pkg::tsc_state_t   state_d;

  logic        aw_held_q;
  logic        w_held_q;
  logic [9:0]  aw_idx_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic [15:0] cfg_q;
  logic [31:0] dly_q;
  logic [31:0] dly_cnt_q;
  logic [5:0]  acc_q;
  logic        sw_start_q;
  logic        sw_stop_q;
  logic        sw_sync_q;
  logic        run_q;
  logic        start_q;
  logic        stop_q;
  logic        load_dly;
  logic        start_fire;
  logic        stop_fire;

  assign axi_rsp     = rsp_q;
  assign acq_run     = run_q;
  assign start_pulse = start_q;
  assign stop_pulse  = stop_q;

  // Write channel: address and data are held independently, so either may come first.
  wire aw_take   = axi_req.awvalid & rsp_q.awready;
  wire w_take    = axi_req.wvalid & rsp_q.wready;
  wire do_write  = aw_held_q & w_held_q & ~rsp_q.bvalid;
  wire aw_held_d = (aw_held_q & ~do_write) | aw_take;
  wire w_held_d  = (w_held_q & ~do_write) | w_take;
  wire bvalid_d  = do_write | (rsp_q.bvalid & ~axi_req.bready);

  // Read channel: data are registered in the same cycle as the address is taken.
  wire       ar_take  = axi_req.arvalid & rsp_q.arready;
  wire       rvalid_d = ar_take | (rsp_q.rvalid & ~axi_req.rready);
  wire [9:0] rd_idx   = axi_req.araddr[11:2];

  // Write decode.
  wire sw_wr   = do_write & (aw_idx_q == tsc_pkg::IDX_STROBE) & wstrb_q[0];
  wire sel_cfg = aw_idx_q == tsc_pkg::IDX_CFG;
  wire sel_chi = aw_idx_q == tsc_pkg::IDX_CFG_HI;
  wire sel_db0 = aw_idx_q == tsc_pkg::IDX_DLY_B0;
  wire sel_db1 = aw_idx_q == tsc_pkg::IDX_DLY_B1;
  wire sel_dw1 = aw_idx_q == tsc_pkg::IDX_DLY_W1;
  wire sel_db3 = aw_idx_q == tsc_pkg::IDX_DLY_B3;

  // The high configuration byte and the odd delay bytes arrive in the low lane.
  wire [1:0]  cfg_be = ~do_write ? 2'h0 :
                       sel_cfg ? wstrb_q[1:0] :
                       sel_chi ? {wstrb_q[0], 1'b0} : 2'h0;
  wire [15:0] cfg_wd = sel_chi ? {wdata_q[7:0], 8'h00} : wdata_q[15:0];
  wire [3:0]  dly_be = ~do_write ? 4'h0 :
                       sel_db0 ? {2'h0, wstrb_q[1:0]} :
                       sel_db1 ? {2'h0, wstrb_q[0], 1'b0} :
                       sel_dw1 ? {wstrb_q[1:0], 2'h0} :
                       sel_db3 ? {wstrb_q[0], 3'h0} : 4'h0;
  wire [31:0] dly_wd = sel_db0 ? {16'h0000, wdata_q[15:0]} :
                       sel_db1 ? {16'h0000, wdata_q[7:0], 8'h00} :
                       sel_dw1 ? {wdata_q[15:0], 16'h0000} :
                       {wdata_q[7:0], 24'h00_0000};

  wire [31:0] cfg_merged = merge_bytes({16'h0000, cfg_q}, {16'h0000, cfg_wd}, {2'h0, cfg_be});
  wire [31:0] dly_merged = merge_bytes(dly_q, dly_wd, dly_be);

  // Configuration fields.
  wire       arm       = cfg_q[tsc_pkg::CFG_ARM_BIT];
  wire [1:0] mode      = cfg_q[tsc_pkg::CFG_MODE_LSB +: 2];
  wire [3:0] start_src = cfg_q[tsc_pkg::CFG_START_LSB +: 4];
  wire [3:0] stop_src  = cfg_q[tsc_pkg::CFG_STOP_LSB +: 4];
  wire [3:0] sync_src  = cfg_q[tsc_pkg::CFG_SYNC_LSB +: 4];

  // Status word and read mux.
  wire [3:0] status = {state_q == tsc_pkg::ST_IDLE, state_q == tsc_pkg::ST_DELAY,
                       state_q == tsc_pkg::ST_WAIT_SYNC, state_q == tsc_pkg::ST_RUN};
  wire [31:0] rd_word = (rd_idx == tsc_pkg::IDX_CFG)    ? {16'h0000, cfg_q} :
                        (rd_idx == tsc_pkg::IDX_CFG_HI) ? {24'h00_0000, cfg_q[15:8]} :
                        (rd_idx == tsc_pkg::IDX_DLY_B0) ? {16'h0000, dly_q[15:0]} :
                        (rd_idx == tsc_pkg::IDX_DLY_B1) ? {24'h00_0000, dly_q[15:8]} :
                        (rd_idx == tsc_pkg::IDX_DLY_W1) ? {16'h0000, dly_q[31:16]} :
                        (rd_idx == tsc_pkg::IDX_DLY_B3) ? {24'h00_0000, dly_q[31:24]} :
                        (rd_idx == tsc_pkg::IDX_STATUS) ? {28'h000_0000, status} :
                        32'h0000_0000;

  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      rsp_q     <= '0;
      aw_held_q <= 1'b0;
      w_held_q  <= 1'b0;
      aw_idx_q  <= 10'h000;
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
    end
    else
    begin
      aw_held_q     <= aw_held_d;
      w_held_q      <= w_held_d;
      rsp_q.awready <= ~aw_held_d;
      rsp_q.wready  <= ~w_held_d;
      rsp_q.bvalid  <= bvalid_d;
      rsp_q.arready <= ~rvalid_d;
      rsp_q.rvalid  <= rvalid_d;
      if (aw_take)
      begin
        aw_idx_q <= axi_req.awaddr[11:2];
      end
      if (w_take)
      begin
        wdata_q <= axi_req.wdata;
        wstrb_q <= axi_req.wstrb;
      end
      if (do_write)
      begin
        rsp_q.bresp <= is_mapped(aw_idx_q) ? tsc_pkg::RESP_OKAY : tsc_pkg::RESP_SLVERR;
      end
      if (ar_take)
      begin
        rsp_q.rdata <= rd_word;
        rsp_q.rresp <= is_mapped(rd_idx) ? tsc_pkg::RESP_OKAY : tsc_pkg::RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      cfg_q <= tsc_pkg::CFG_RESET;
      dly_q <= tsc_pkg::DLY_RESET;
    end
    else
    begin
      cfg_q <= cfg_merged[15:0] & tsc_pkg::CFG_WRITE_MASK;
      dly_q <= dly_merged;
    end
  end

  // A strobe byte that matches none of the three codes leaves every pulse low.
  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      sw_start_q <= 1'b0;
      sw_stop_q  <= 1'b0;
      sw_sync_q  <= 1'b0;
    end
    else
    begin
      sw_start_q <= sw_wr & (wdata_q[7:0] == tsc_pkg::STROBE_START);
      sw_stop_q  <= sw_wr & (wdata_q[7:0] == tsc_pkg::STROBE_STOP);
      sw_sync_q  <= sw_wr & (wdata_q[7:0] == tsc_pkg::STROBE_SYNC);
    end
  end

  logic [5:0] edge_rise;
  logic [5:0] edge_fall;

  tsc_edge_sync #(
    .WIDTH (6)
  ) u_edges (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .sig_in   ({digital_input_3, digital_input_2, digital_input_1, digital_input_0,
                timer2_output, timer0_output}),
    .rise     (edge_rise),
    .fall     (edge_fall)
  );

  // Codes 4 upward pair rising and falling edges: timer 0, timer 2, then inputs 0 to 3.
  logic [11:0] edge_vec;
  for (genvar i = 0; i < 6; i++)
  begin : g_edge
    assign edge_vec[2*i]     = edge_rise[i];
    assign edge_vec[2*i + 1] = edge_fall[i];
  end

  // Bit 0 is the empty selection; the frame maximum exists for the stop selector only.
  wire [15:0] start_vec = {edge_vec, ai_frame_timer, 1'b0, sw_start_q, 1'b0};
  wire [15:0] stop_vec  = {edge_vec, ai_frame_timer, ai_frame_max, sw_stop_q, 1'b0};
  wire [15:0] sync_vec  = {edge_vec, ai_frame_timer, 1'b0, sw_sync_q, 1'b0};

  wire start_ev = arm & pick_event(start_vec, start_src);
  wire stop_ev  = arm & pick_event(stop_vec, stop_src);
  wire sync_ev  = arm & pick_event(sync_vec, sync_src);

  // The 25 ns step is not a whole number of clocks, so nanoseconds are accumulated
  // and a step tick is taken whenever a full step has gone by.
  wire [5:0] acc_sum  = acc_q + tsc_pkg::CLK_PERIOD_NS;
  wire       step_tick = acc_sum >= tsc_pkg::DELAY_STEP_NS;
  wire [5:0] acc_d    = step_tick ? acc_sum - tsc_pkg::DELAY_STEP_NS : acc_sum;

  always_comb
  begin
    state_d    = state_q;
    load_dly   = 1'b0;
    start_fire = 1'b0;
    stop_fire  = 1'b0;
    if (!arm)
    begin
      state_d = tsc_pkg::ST_IDLE;
    end
    else
    begin
      unique case (state_q)
        tsc_pkg::ST_IDLE:
        begin
          if (start_ev)
          begin
            unique case (mode)
              tsc_pkg::MODE_DELAY:
              begin
                state_d  = tsc_pkg::ST_DELAY;
                load_dly = 1'b1;
              end
              tsc_pkg::MODE_SYNC_DELAY:
              begin
                state_d = tsc_pkg::ST_WAIT_SYNC;
              end
              default:
              begin
                // The reserved mode code behaves as a direct start.
                state_d    = tsc_pkg::ST_RUN;
                start_fire = 1'b1;
              end
            endcase
          end
        end
        tsc_pkg::ST_WAIT_SYNC:
        begin
          if (sync_ev)
          begin
            state_d  = tsc_pkg::ST_DELAY;
            load_dly = 1'b1;
          end
        end
        tsc_pkg::ST_DELAY:
        begin
          if (dly_cnt_q == 32'h0000_0000)
          begin
            state_d    = tsc_pkg::ST_RUN;
            start_fire = 1'b1;
          end
        end
        tsc_pkg::ST_RUN:
        begin
          if (stop_ev)
          begin
            state_d   = tsc_pkg::ST_IDLE;
            stop_fire = 1'b1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      state_q   <= tsc_pkg::ST_IDLE;
      dly_cnt_q <= 32'h0000_0000;
      acc_q     <= 6'h00;
      run_q     <= 1'b0;
      start_q   <= 1'b0;
      stop_q    <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      run_q   <= state_d == tsc_pkg::ST_RUN;
      start_q <= start_fire;
      stop_q  <= stop_fire;
      acc_q   <= load_dly ? 6'h00 : acc_d;
      if (load_dly)
      begin
        dly_cnt_q <= dly_q;
      end
      else if ((state_q == tsc_pkg::ST_DELAY) && step_tick && (dly_cnt_q != 32'h0000_0000))
      begin
        dly_cnt_q <= dly_cnt_q - 32'h0000_0001;
      end
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  sequence s_idle_start(logic [1:0] m);
    (state_q == tsc_pkg::ST_IDLE) && arm && start_ev && (mode == m);
  endsequence

  chk_disarm_quiet: assert property (!arm |=> !start_q && !stop_q)
    else $error("Trigger activity while disarmed.");

  chk_direct_start: assert property (s_idle_start(tsc_pkg::MODE_DIRECT)
                                     |=> run_q && start_q)
    else $error("Direct start did not begin acquisition.");

  chk_delay_entry: assert property (s_idle_start(tsc_pkg::MODE_DELAY)
                                    |=> state_q == tsc_pkg::ST_DELAY && !run_q)
    else $error("Delayed start did not enter the delay.");

  chk_sync_wait: assert property (s_idle_start(tsc_pkg::MODE_SYNC_DELAY)
                                  |=> state_q == tsc_pkg::ST_WAIT_SYNC)
    else $error("Synchronised start did not wait for sync.");

  chk_none_source: assert property (start_src == tsc_pkg::SRC_NONE |-> !start_ev)
    else $error("Empty start selector produced an event.");

  chk_strobe_start: assert property (sw_wr && wdata_q[7:0] == tsc_pkg::STROBE_START
                                     && start_src == tsc_pkg::SRC_SOFT && arm
                                     && $stable(cfg_q) |=> start_ev)
    else $error("Start strobe was lost.");

  chk_strobe_match: assert property (sw_stop_q |-> $past(wdata_q[7:0]) == tsc_pkg::STROBE_STOP
                                     && $past(sw_wr))
    else $error("Stop strobe from a wrong byte.");

  chk_frame_stop: assert property (arm && stop_src == tsc_pkg::SRC_FRAME_MAX && ai_frame_max
                                   |-> stop_ev)
    else $error("Frame maximum did not raise stop.");

  chk_delay_zero: assert property (state_q == tsc_pkg::ST_DELAY && arm
                                   && dly_cnt_q == 32'h0000_0000 |=> run_q && start_q)
    else $error("Expired delay did not start acquisition.");

  chk_stop_ends: assert property (state_q == tsc_pkg::ST_RUN && stop_ev
                                  |=> !run_q && stop_q ##1 !stop_q)
    else $error("Stop event did not end the run.");

endmodule : tsc_trigger_ctrl

// ### trigger_start_stop_control_bench.sv
`timescale 1ns/1ps
module trigger_start_stop_control_bench;
  logic                  core_clk    = 1'b0;
  logic                  reset_n     = 1'b0;
  tsc_pkg::tsc_axi_req_t req         = '0;
  tsc_pkg::tsc_axi_rsp_t rsp;
  logic [5:0]            pins        = 6'h00;
  logic                  fmax        = 1'b0;
  logic                  ftmr        = 1'b0;
  logic                  acq_run;
  logic                  start_pulse;
  logic                  stop_pulse;
  logic [33:0]           bus_q[$];
  logic [1:0]            ev_q[$];
  logic [15:0]           lfsr        = 16'h0010;
  int                    n_fail      = 0;
  int                    check_count = 0;

  always #4 core_clk = ~core_clk;

  tsc_trigger_ctrl u_dut (
    .core_clk        (core_clk),
    .reset_n         (reset_n),
    .axi_req         (req),
    .axi_rsp         (rsp),
    .timer0_output   (pins[0]),
    .timer2_output   (pins[1]),
    .digital_input_0 (pins[2]),
    .digital_input_1 (pins[3]),
    .digital_input_2 (pins[4]),
    .digital_input_3 (pins[5]),
    .ai_frame_max    (fmax),
    .ai_frame_timer  (ftmr),
    .acq_run         (acq_run),
    .start_pulse     (start_pulse),
    .stop_pulse      (stop_pulse)
  );

  function automatic logic [15:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr;
  endfunction : rnd

  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : finish_test

  task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // An empty note queue means the pulse was never asked for.
  function automatic logic [33:0] ev_pop();
    if (ev_q.size() == 0)
      return 34'h3;
    return {32'h0000_0000, ev_q.pop_front()};
  endfunction : ev_pop

  always @(posedge core_clk)
  begin
    if (rsp.bvalid && req.bready)
      chk({rsp.bresp, 32'h0000_0000}, bus_q.pop_front());
    if (rsp.rvalid && req.rready)
      chk({rsp.rresp, rsp.rdata}, bus_q.pop_front());
    if (start_pulse)
      chk(34'h1, ev_pop());
    if (stop_pulse)
      chk(34'h2, ev_pop());
  end

  task automatic axi(input bit wr, input logic [9:0] i, input logic [31:0] d,
                     input logic [3:0] s, input logic [33:0] e);
    int n;
    n = 0;
    bus_q.push_back(e);
    if (wr)
    begin
      req.awaddr  <= {i, 2'b00};
      req.wdata   <= d;
      req.wstrb   <= s;
      req.awvalid <= 1'b1;
      req.wvalid  <= 1'b1;
      req.bready  <= 1'b1;
    end
    else
    begin
      req.araddr  <= {i, 2'b00};
      req.arvalid <= 1'b1;
      req.rready  <= 1'b1;
    end
    do
    begin
      @(posedge core_clk);
      n++;
      if (req.awvalid && rsp.awready)
        req.awvalid <= 1'b0;
      if (req.wvalid && rsp.wready)
        req.wvalid <= 1'b0;
      if (req.arvalid && rsp.arready)
        req.arvalid <= 1'b0;
      if (n > 200)
      begin
        n_fail++;
        finish_test();
      end
    end while (!(rsp.bvalid && req.bready) && !(rsp.rvalid && req.rready));
    req.bready <= 1'b0;
    req.rready <= 1'b0;
    @(posedge core_clk);
  endtask : axi

  task automatic wr(input logic [9:0] i, input logic [31:0] d, input logic [3:0] s);
    axi(1'b1, i, d, s, {tsc_pkg::RESP_OKAY, 32'h0000_0000});
  endtask : wr

  task automatic rd(input logic [9:0] i, input logic [31:0] e);
    axi(1'b0, i, 32'h0000_0000, 4'h0, {tsc_pkg::RESP_OKAY, e});
  endtask : rd

  task automatic sb(input logic [7:0] code);
    wr(tsc_pkg::IDX_STROBE, {24'h00_0000, code}, 4'h1);
  endtask : sb

  task automatic cfg(input logic arm, input logic [1:0] mode, input logic [3:0] sy,
                     input logic [3:0] sp, input logic [3:0] st);
    wr(tsc_pkg::IDX_CFG, {16'h0000, arm, 1'b0, mode, sy, sp, st}, 4'h3);
  endtask : cfg

  task automatic fp(input bit m);
    if (m)
      fmax <= 1'b1;
    else
      ftmr <= 1'b1;
    @(posedge core_clk);
    fmax <= 1'b0;
    ftmr <= 1'b0;
    @(posedge core_clk);
  endtask : fp

  task automatic wrun(input logic lvl, output int dt);
    dt = 0;
    while (acq_run !== lvl)
    begin
      @(posedge core_clk);
      dt++;
      if (dt > 3000)
      begin
        n_fail++;
        finish_test();
      end
    end
  endtask : wrun

  initial
  begin
    int          dt;
    int          c;
    int          p;
    int          ex;
    logic [31:0] v;
    repeat (20) @(posedge core_clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    rd(tsc_pkg::IDX_CFG, 32'h0000_0000);
    rd(tsc_pkg::IDX_DLY_B0, 32'h0000_0000);
    axi(1'b0, 10'h020, 32'h0000_0000, 4'h0, {tsc_pkg::RESP_SLVERR, 32'h0000_0000});
    axi(1'b1, 10'h020, 32'h0000_FFFF, 4'hF, {tsc_pkg::RESP_SLVERR, 32'h0000_0000});
    // Mode bits are written as 10: software never programs the reserved mode.
    wr(tsc_pkg::IDX_CFG, 32'h0000_EFFF, 4'h3);
    rd(tsc_pkg::IDX_CFG, 32'h0000_AFFF);
    rd(tsc_pkg::IDX_CFG_HI, 32'h0000_00AF);
    wr(tsc_pkg::IDX_CFG_HI, 32'h0000_0012, 4'h1);
    rd(tsc_pkg::IDX_CFG, 32'h0000_12FF);
    rd(tsc_pkg::IDX_STATUS, 32'h0000_0008);
    $display("test registers done");
    v = {rnd(), rnd()};
    for (c = 0; c < 4; c++)
      wr(tsc_pkg::IDX_DLY_B0 + 10'(c), {24'h00_0000, v[8*c +: 8]}, 4'h1);
    for (c = 0; c < 4; c++)
      rd(tsc_pkg::IDX_DLY_B0 + 10'(c), c[0] ? {24'h0, v[8*c +: 8]} : {16'h0, v[8*c +: 16]});
    $display("test delay access done");
    cfg(1'b0, 2'h0, 4'h1, 4'h1, 4'h1);
    sb(tsc_pkg::STROBE_START);
    cfg(1'b1, 2'h0, 4'h0, 4'h0, 4'h0);
    sb(tsc_pkg::STROBE_START);
    // Random pin and frame activity must stay silent with every selector empty.
    repeat (8)
    begin
      v[15:0] = rnd();
      pins <= v[5:0];
      fmax <= v[6];
      ftmr <= v[7];
      @(posedge core_clk);
    end
    fmax <= 1'b0;
    ftmr <= 1'b0;
    repeat (6) @(posedge core_clk);
    chk({33'h0, acq_run}, 34'h0);
    $display("test disabled done");
    cfg(1'b1, 2'h0, 4'h1, 4'h1, 4'h1);
    for (c = 0; c < 2; c++)
    begin
      sb(tsc_pkg::STROBE_SYNC);
      ev_q.push_back(2'h1);
      sb(tsc_pkg::STROBE_START);
      wrun(1'b1, dt);
      chk(34'(dt <= 3), 34'h1);
      rd(tsc_pkg::IDX_STATUS, 32'h0000_0001);
      sb(tsc_pkg::STROBE_START);
      ev_q.push_back(2'h2);
      sb(tsc_pkg::STROBE_STOP);
      wrun(1'b0, dt);
    end
    $display("test direct done");
    for (c = 0; c < 2; c++)
    begin
      wr(tsc_pkg::IDX_DLY_B0, 32'h0000_0000 + 16 * c, 4'h3);
      wr(tsc_pkg::IDX_DLY_W1, 32'h0000_0000, 4'h3);
      cfg(1'b1, 2'h1, 4'h0, 4'h1, 4'h1);
      ex = 16 * c * 25 / 8;
      ev_q.push_back(2'h1);
      sb(tsc_pkg::STROBE_START);
      wrun(1'b1, dt);
      chk(34'(dt >= ex && dt <= ex + 6), 34'h1);
      ev_q.push_back(2'h2);
      sb(tsc_pkg::STROBE_STOP);
      wrun(1'b0, dt);
    end
    cfg(1'b1, 2'h2, 4'h1, 4'h1, 4'h1);
    sb(tsc_pkg::STROBE_START);
    repeat (6) @(posedge core_clk);
    chk({33'h0, acq_run}, 34'h0);
    rd(tsc_pkg::IDX_STATUS, 32'h0000_0002);
    ev_q.push_back(2'h1);
    sb(tsc_pkg::STROBE_SYNC);
    wrun(1'b1, dt);
    ev_q.push_back(2'h2);
    sb(tsc_pkg::STROBE_STOP);
    wrun(1'b0, dt);
    $display("test delay modes done");
    cfg(1'b1, 2'h0, 4'h0, 4'h2, 4'h2);
    pins <= 6'h00;
    fp(1'b1);
    repeat (4) @(posedge core_clk);
    chk({33'h0, acq_run}, 34'h0);
    cfg(1'b1, 2'h2, 4'h3, 4'h2, 4'h3);
    fp(1'b0);
    repeat (4) @(posedge core_clk);
    ev_q.push_back(2'h1);
    fp(1'b0);
    wrun(1'b1, dt);
    ev_q.push_back(2'h2);
    fp(1'b1);
    wrun(1'b0, dt);
    cfg(1'b1, 2'h0, 4'h0, 4'h3, 4'h3);
    ev_q.push_back(2'h1);
    fp(1'b0);
    wrun(1'b1, dt);
    ev_q.push_back(2'h2);
    fp(1'b0);
    wrun(1'b0, dt);
    $display("test frame sources done");
    for (c = 4; c < 16; c++)
    begin
      p = (c - 4) / 2;
      cfg(1'b1, 2'h0, 4'h0, 4'(c), 4'(c));
      ev_q.push_back(2'h1);
      pins[p] <= ~c[0];
      wrun(1'b1, dt);
      chk(34'(dt <= 6), 34'h1);
      // The opposite edge must not count as a stop event.
      pins[p] <= c[0];
      repeat (6) @(posedge core_clk);
      ev_q.push_back(2'h2);
      pins[p] <= ~c[0];
      wrun(1'b0, dt);
    end
    $display("test pin sources done");
    repeat (6) @(posedge core_clk);
    chk(34'(ev_q.size()), 34'h0);
    finish_test();
  end
endmodule : trigger_start_stop_control_bench
